// file: pkg/rvmss_pkg.sv
// constants for the relocatable vector map and source select block
package rvmss_pkg;
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 24;
  localparam int          VEC_NUM_W     = 6;
  localparam int          VEC_COUNT     = 64;
  localparam int          VEC_BYTES     = 4;
  localparam int          BASE_W        = 20;
  // register offsets as printed
  localparam logic [11:0] OFS_SEL_THIRD  = 12'h205;
  localparam logic [11:0] OFS_SEL_SECOND = 12'h206;
  localparam logic [11:0] OFS_SEL_MAIN   = 12'h207;
  localparam logic [11:0] OFS_AM_EN      = 12'h20E;
  localparam logic [11:0] OFS_AM_EN_UP   = 12'h20F;
  localparam logic [11:0] OFS_AM_VAL0    = 12'h210;
  localparam logic [11:0] OFS_AM_VAL1    = 12'h214;
  localparam logic [11:0] OFS_AM_VAL2    = 12'h218;
  localparam logic [11:0] OFS_AM_VAL3    = 12'h21C;
  localparam logic [7:0]  SEL_RESET      = 8'h00;
  localparam logic [23:0] AM_VAL_RESET   = 24'h000000;
  // field positions in the second source-select register
  localparam int          SEL2_I2C      = 2;
  localparam int          SEL2_SCLSDA   = 3;
  localparam int          SEL2_REMOTE0  = 4;
  localparam int          SEL2_REMOTE1  = 5;
  localparam int          SEL2_SER0     = 6;
  localparam int          SEL2_SER1     = 7;
  // interrupt vector numbers
  localparam int          VEC_TMR_B4    = 6;
  localparam int          VEC_TMR_B3    = 7;
  localparam int          VEC_EXT0      = 29;
  localparam int          VEC_EXT1      = 30;
  localparam int          VEC_EXT2      = 31;
  localparam int          VEC_SW_A_LO   = 32;
  localparam int          VEC_SW_A_HI   = 40;
  localparam int          VEC_DMA2      = 41;
  localparam int          VEC_DMA3      = 42;
  localparam int          VEC_S5_SS     = 43;
  localparam int          VEC_S5_TX     = 44;
  localparam int          VEC_S5_RX     = 45;
  localparam int          VEC_S6_SS     = 46;
  localparam int          VEC_S6_TX     = 47;
  localparam int          VEC_S6_RX     = 48;
  localparam int          VEC_S7_SS     = 49;
  localparam int          VEC_S7_TX     = 50;
  localparam int          VEC_S7_RX     = 51;
  localparam int          VEC_SW_B_LO   = 52;
  localparam int          VEC_SW_B_HI   = 58;
  localparam int          VEC_I2C       = 59;
  localparam int          VEC_SCLSDA    = 60;
  localparam int          VEC_SW_C_LO   = 61;
  localparam int          VEC_SW_C_HI   = 63;
  localparam int          VEC_LOW_HW_LO = 4;
  localparam int          VEC_LOW_HW_HI = 28;
endpackage : rvmss_pkg

// file: verilog/rvmss_top.sv
// vector map, pending requests and source-select routing for vectors 6, 7, 29..31, 41..51, 59 and 60
`timescale 1ns/1ps
module rvmss_top
  import rvmss_pkg::*;
(
  input  wire logic                 ref_clk_in,
  input  wire logic                 resetn_in,
  // register port
  input  wire logic [ADDR_W-1:0]    reg_addr_in,
  input  wire logic [DATA_W-1:0]    reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  output logic      [DATA_W-1:0]    reg_rdata_out,
  // external interrupt pins, active low, asynchronous
  input  wire logic                 external_irq_pin_zero_in,
  input  wire logic                 external_irq_pin_one_in,
  input  wire logic                 external_irq_pin_two_in,
  // peripheral event pulses on ref_clk_in
  input  wire logic                 dma2_done_in,
  input  wire logic                 dma3_done_in,
  input  wire logic                 serial5_ss_in,
  input  wire logic                 serial5_tx_in,
  input  wire logic                 serial5_not_acknowledge_in,
  input  wire logic                 serial5_rx_in,
  input  wire logic                 serial5_acknowledge_in,
  input  wire logic                 cec1_in,
  input  wire logic                 cec2_in,
  input  wire logic                 serial6_ss_in,
  input  wire logic                 serial6_tx_in,
  input  wire logic                 serial6_not_acknowledge_in,
  input  wire logic                 serial6_rx_in,
  input  wire logic                 serial6_acknowledge_in,
  input  wire logic                 rtc_period_in,
  input  wire logic                 rtc_compare_in,
  input  wire logic                 serial7_ss_in,
  input  wire logic                 serial7_tx_in,
  input  wire logic                 serial7_not_acknowledge_in,
  input  wire logic                 serial7_rx_in,
  input  wire logic                 serial7_acknowledge_in,
  input  wire logic                 remote0_in,
  input  wire logic                 remote1_in,
  input  wire logic                 i2c_in,
  input  wire logic                 scl_sda_in,
  input  wire logic                 timer_b3_in,
  input  wire logic                 timer_b4_in,
  input  wire logic                 serial0_ss_in,
  input  wire logic                 serial1_ss_in,
  // cpu side
  input  wire logic [BASE_W-1:0]    table_base_in,
  input  wire logic                 fetch_req_in,
  input  wire logic [VEC_NUM_W-1:0] fetch_num_in,
  output logic      [VEC_COUNT-1:0] pending_out,
  output logic      [BASE_W-1:0]    vec_addr_out,
  output logic                      vec_valid_out,
  output logic                      vec_hw_out
);

  // reset release synchroniser
  logic rst_s1_r;
  logic rst_s2_r;
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire logic rstn = rst_s2_r;

  // true when a vector number has a hardware request source
  function automatic logic vec_has_hw(input logic [VEC_NUM_W-1:0] n);
    int v;
    v = int'(n);
    vec_has_hw = (v >= VEC_LOW_HW_LO && v <= VEC_LOW_HW_HI)
              || (v >= VEC_EXT0 && v <= VEC_EXT2)
              || (v >= VEC_DMA2 && v <= VEC_S7_RX)
              || v == VEC_I2C || v == VEC_SCLSDA;
  endfunction : vec_has_hw

  // software registers
  logic [7:0]        sel_third_r;
  logic [7:0]        sel_second_r;
  logic [7:0]        sel_main_r;
  logic [7:0]        am_en_r;
  logic [7:0]        am_en_up_r;
  logic [DATA_W-1:0] am_val_r [4];

  // register writes; reserved widths are simply truncated
  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      sel_third_r  <= SEL_RESET;
      sel_second_r <= SEL_RESET;
      sel_main_r   <= SEL_RESET;
      am_en_r      <= SEL_RESET;
      am_en_up_r   <= SEL_RESET;
      for (int i = 0; i < 4; i++) begin
        am_val_r[i] <= AM_VAL_RESET;
      end
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        OFS_SEL_THIRD:  sel_third_r  <= reg_wdata_in[7:0];
        OFS_SEL_SECOND: sel_second_r <= reg_wdata_in[7:0];
        OFS_SEL_MAIN:   sel_main_r   <= reg_wdata_in[7:0];
        OFS_AM_EN:      am_en_r      <= reg_wdata_in[7:0];
        OFS_AM_EN_UP:   am_en_up_r   <= reg_wdata_in[7:0];
        OFS_AM_VAL0:    am_val_r[0]  <= reg_wdata_in;
        OFS_AM_VAL1:    am_val_r[1]  <= reg_wdata_in;
        OFS_AM_VAL2:    am_val_r[2]  <= reg_wdata_in;
        OFS_AM_VAL3:    am_val_r[3]  <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        OFS_SEL_THIRD:  reg_rdata_out <= {16'h0000, sel_third_r};
        OFS_SEL_SECOND: reg_rdata_out <= {16'h0000, sel_second_r};
        OFS_SEL_MAIN:   reg_rdata_out <= {16'h0000, sel_main_r};
        OFS_AM_EN:      reg_rdata_out <= {16'h0000, am_en_r};
        OFS_AM_EN_UP:   reg_rdata_out <= {16'h0000, am_en_up_r};
        OFS_AM_VAL0:    reg_rdata_out <= am_val_r[0];
        OFS_AM_VAL1:    reg_rdata_out <= am_val_r[1];
        OFS_AM_VAL2:    reg_rdata_out <= am_val_r[2];
        OFS_AM_VAL3:    reg_rdata_out <= am_val_r[3];
        default:        reg_rdata_out <= '0;
      endcase
    end else begin
      reg_rdata_out <= '0;
    end
  end

  // pins are asynchronous: two flops, then a falling-edge detector
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;
  logic [2:0] pin_s3_r;
  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      pin_s1_r <= 3'h7;
      pin_s2_r <= 3'h7;
      pin_s3_r <= 3'h7;
    end else begin
      pin_s1_r <= {external_irq_pin_two_in, external_irq_pin_one_in,
                   external_irq_pin_zero_in};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end
  wire logic [2:0] pin_fall = pin_s3_r & ~pin_s2_r;

  // routing of sources onto vectors; gating is per cycle, so a source
  // that is deselected can never set a request once the bit has moved
  logic [VEC_COUNT-1:0] req_vec;
  always_comb begin
    req_vec = '0;
    req_vec[VEC_TMR_B3] = sel_second_r[SEL2_SER0] ? serial0_ss_in
                                                  : timer_b3_in;
    req_vec[VEC_TMR_B4] = sel_second_r[SEL2_SER1] ? serial1_ss_in
                                                  : timer_b4_in;
    req_vec[VEC_EXT0]  = pin_fall[0];
    req_vec[VEC_EXT1]  = pin_fall[1];
    req_vec[VEC_EXT2]  = pin_fall[2];
    req_vec[VEC_DMA2]  = dma2_done_in;
    req_vec[VEC_DMA3]  = dma3_done_in;
    req_vec[VEC_S5_SS] = serial5_ss_in | cec1_in;
    req_vec[VEC_S5_TX] = serial5_tx_in | serial5_not_acknowledge_in
                       | cec2_in;
    req_vec[VEC_S5_RX] = serial5_rx_in | serial5_acknowledge_in;
    req_vec[VEC_S6_SS] = serial6_ss_in | rtc_period_in;
    req_vec[VEC_S6_TX] = serial6_tx_in | serial6_not_acknowledge_in
                       | rtc_compare_in;
    req_vec[VEC_S6_RX] = serial6_rx_in | serial6_acknowledge_in;
    req_vec[VEC_S7_SS] = sel_second_r[SEL2_REMOTE0] ? remote0_in
                       : serial7_ss_in;
    req_vec[VEC_S7_TX] = sel_second_r[SEL2_REMOTE1] ? remote1_in
                       : (serial7_tx_in | serial7_not_acknowledge_in);
    req_vec[VEC_S7_RX] = serial7_rx_in | serial7_acknowledge_in;
    req_vec[VEC_I2C]    = sel_second_r[SEL2_I2C] & i2c_in;
    req_vec[VEC_SCLSDA] = sel_second_r[SEL2_SCLSDA] & scl_sda_in;
    // vectors 32..40, 52..58, 61..63 stay zero: software only
  end

  // one sticky pending bit per vector; a new request beats the fetch clear
  wire logic [VEC_COUNT-1:0] fetch_clr =
    fetch_req_in ? (VEC_COUNT'(1) << fetch_num_in) : '0;
  genvar g;
  generate
    for (g = 0; g < VEC_COUNT; g++) begin : g_pend
      always_ff @(posedge ref_clk_in or negedge rstn) begin
        if (!rstn) begin
          pending_out[g] <= 1'b0;
        end else if (req_vec[g]) begin
          pending_out[g] <= 1'b1;
        end else if (fetch_clr[g]) begin
          pending_out[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // vector address: table base plus four bytes per number
  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      vec_addr_out  <= '0;
      vec_valid_out <= 1'b0;
      vec_hw_out    <= 1'b0;
    end else begin
      vec_valid_out <= fetch_req_in;
      if (fetch_req_in) begin
        vec_addr_out <= table_base_in
                      + BASE_W'({fetch_num_in, 2'b00});
        vec_hw_out   <= vec_has_hw(fetch_num_in);
      end
    end
  end

  // checks
  p_ext0 : assert property (@(posedge ref_clk_in) disable iff (!rstn)
    pin_s3_r[0] && !pin_s2_r[0] && !fetch_req_in |=> pending_out[VEC_EXT0])
    else $error("pin zero edge did not pend vector 29");
  property p_addr;
    @(posedge ref_clk_in) disable iff (!rstn)
      fetch_req_in |=> vec_valid_out && vec_addr_out ==
        $past(table_base_in) + BASE_W'({$past(fetch_num_in), 2'b00});
  endproperty
  a_addr : assert property (p_addr)
    else $error("vector address not base plus four times number");
  property p_addr41;
    @(posedge ref_clk_in) disable iff (!rstn)
      fetch_req_in && fetch_num_in == 6'h29 && table_base_in == '0
      |=> vec_addr_out == 20'h000A4;
  endproperty
  a_addr41 : assert property (p_addr41)
    else $error("vector 41 not at offset 164");
  property p_sw_only;
    @(posedge ref_clk_in) disable iff (!rstn)
      fetch_req_in && (fetch_num_in inside {[32:40], [52:58], [61:63]})
      |=> !vec_hw_out;
  endproperty
  a_sw_only : assert property (p_sw_only)
    else $error("software-only vector flagged as hardware");
  property p_sw_quiet;
    @(posedge ref_clk_in) disable iff (!rstn)
      $rose(pending_out[VEC_SW_B_LO]) |-> $past(fetch_req_in) == 1'b0
      && 1'b0;
  endproperty
  a_sw_quiet : assert property (p_sw_quiet)
    else $error("software-only vector pended by hardware");
  property p_i2c_gate;
    @(posedge ref_clk_in) disable iff (!rstn)
      !sel_second_r[SEL2_I2C] && !pending_out[VEC_I2C] |=>
        !pending_out[VEC_I2C];
  endproperty
  a_i2c_gate : assert property (p_i2c_gate)
    else $error("i2c pended while unselected");
  property p_remote0;
    @(posedge ref_clk_in) disable iff (!rstn)
      sel_second_r[SEL2_REMOTE0] && remote0_in |=> pending_out[VEC_S7_SS];
  endproperty
  a_remote0 : assert property (p_remote0)
    else $error("remote receiver zero not routed to vector 49");
  property p_desel;
    @(posedge ref_clk_in) disable iff (!rstn)
      sel_second_r[SEL2_REMOTE1] && !remote1_in
      && !pending_out[VEC_S7_TX] |=> !pending_out[VEC_S7_TX];
  endproperty
  a_desel : assert property (p_desel)
    else $error("deselected serial7 transmit set vector 50");
  property p_set_wins;
    @(posedge ref_clk_in) disable iff (!rstn)
      req_vec[VEC_DMA2] |=> pending_out[VEC_DMA2] [*1];
  endproperty
  a_set_wins : assert property (p_set_wins)
    else $error("dma2 request lost against a clear");
  property p_tb3;
    @(posedge ref_clk_in) disable iff (!rstn)
      !sel_second_r[SEL2_SER0] && timer_b3_in ##1 !fetch_req_in
      |-> pending_out[VEC_TMR_B3];
  endproperty
  a_tb3 : assert property (p_tb3)
    else $error("timer b3 not routed to vector 7");
  c_fetch  : cover property (@(posedge ref_clk_in) disable iff (!rstn)
    fetch_req_in && pending_out[fetch_num_in]);
  c_remote : cover property (@(posedge ref_clk_in) disable iff (!rstn)
    $rose(sel_second_r[SEL2_REMOTE1]) ##[1:20] remote1_in);
  c_i2c    : cover property (@(posedge ref_clk_in) disable iff (!rstn)
    $rose(pending_out[VEC_I2C]));

endmodule : rvmss_top

// file: verification/rvmss_cpu_model.sv
// cpu side model: issues one vector fetch per request and keeps the answer
`timescale 1ns/1ps
module rvmss_cpu_model
  import rvmss_pkg::*;
(
  input  wire logic                 ref_clk_in,
  input  wire logic                 resetn_in,
  input  wire logic                 go_in,
  input  wire logic [VEC_NUM_W-1:0] num_in,
  input  wire logic                 vec_valid_in,
  input  wire logic [BASE_W-1:0]    vec_addr_in,
  input  wire logic                 vec_hw_in,
  output logic                      fetch_req_out,
  output logic      [VEC_NUM_W-1:0] fetch_num_out,
  output logic                      done_out,
  output logic      [BASE_W-1:0]    addr_out,
  output logic                      hw_out
);
  // one-cycle fetch pulse; the number is scrambled outside the pulse so
  // a design that samples it late sees junk rather than a lucky value
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fetch_req_out <= 1'b0;
      fetch_num_out <= 6'h00;
    end else begin
      fetch_req_out <= go_in;
      fetch_num_out <= go_in ? num_in : ~fetch_num_out;
    end
  end
  // take the entry on the edge where valid is seen high
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_out <= 1'b0;
      addr_out <= 20'h00000;
      hw_out   <= 1'b0;
    end else begin
      done_out <= vec_valid_in;
      if (vec_valid_in) begin
        addr_out <= vec_addr_in;
        hw_out   <= vec_hw_in;
      end
    end
  end
endmodule : rvmss_cpu_model

// file: verification/tb_top.sv
// self-checking bench for the vector map and source select block
`timescale 1ns/1ps
module tb_top;
  import rvmss_pkg::*;
  logic ref_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [ADDR_W-1:0] addr = 12'h000;
  logic [DATA_W-1:0] wdata = 24'h000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [2:0] pin = 3'h7;
  logic [28:0] ev = 29'h0;
  logic [BASE_W-1:0] base = 20'h00000;
  logic go = 1'b0;
  logic [VEC_NUM_W-1:0] num = 6'h00;
  logic freq, done, vvalid, vhw, mhw;
  logic [VEC_NUM_W-1:0] fnum;
  logic [BASE_W-1:0] vaddr, maddr;
  logic [VEC_COUNT-1:0] pending_out;
  int n_errors = 0;
  int compares = 0;
  // rows: event index, second select value, vector (FF: must not pend)
  localparam logic [23:0] ROWS [39] = '{
    24'h000029, 24'h01002A, 24'h02002B, 24'h03002B, 24'h04002C, 24'h05002C,
    24'h06002C, 24'h07002D, 24'h08002D, 24'h09002E, 24'h0A002E, 24'h0B002F,
    24'h0C002F, 24'h0D002F, 24'h0E0030, 24'h0F0030, 24'h100031, 24'h111031,
    24'h120032, 24'h130032, 24'h142032, 24'h150033, 24'h160033, 24'h17043B,
    24'h18083C, 24'h190007, 24'h1A4007, 24'h1B0006, 24'h1C8006, 24'h1100FF,
    24'h1010FF, 24'h1400FF, 24'h1220FF, 24'h1700FF, 24'h1800FF, 24'h1940FF,
    24'h1A00FF, 24'h1B80FF, 24'h1C00FF};
  localparam logic [11:0] OFS [9] = '{OFS_SEL_THIRD, OFS_SEL_SECOND,
    OFS_SEL_MAIN, OFS_AM_EN, OFS_AM_EN_UP, OFS_AM_VAL0, OFS_AM_VAL1,
    OFS_AM_VAL2, OFS_AM_VAL3};

  always #4 ref_clk_in = ~ref_clk_in;

  rvmss_top u_dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata),
    .external_irq_pin_zero_in(pin[0]), .external_irq_pin_one_in(pin[1]),
    .external_irq_pin_two_in(pin[2]), .dma2_done_in(ev[0]),
    .dma3_done_in(ev[1]), .serial5_ss_in(ev[2]), .cec1_in(ev[3]),
    .serial5_tx_in(ev[4]), .serial5_not_acknowledge_in(ev[5]),
    .cec2_in(ev[6]), .serial5_rx_in(ev[7]), .serial5_acknowledge_in(ev[8]),
    .serial6_ss_in(ev[9]), .rtc_period_in(ev[10]), .serial6_tx_in(ev[11]),
    .serial6_not_acknowledge_in(ev[12]), .rtc_compare_in(ev[13]),
    .serial6_rx_in(ev[14]), .serial6_acknowledge_in(ev[15]),
    .serial7_ss_in(ev[16]), .remote0_in(ev[17]), .serial7_tx_in(ev[18]),
    .serial7_not_acknowledge_in(ev[19]), .remote1_in(ev[20]),
    .serial7_rx_in(ev[21]), .serial7_acknowledge_in(ev[22]),
    .i2c_in(ev[23]), .scl_sda_in(ev[24]), .timer_b3_in(ev[25]),
    .serial0_ss_in(ev[26]), .timer_b4_in(ev[27]), .serial1_ss_in(ev[28]),
    .table_base_in(base), .fetch_req_in(freq), .fetch_num_in(fnum),
    .pending_out(pending_out), .vec_addr_out(vaddr),
    .vec_valid_out(vvalid), .vec_hw_out(vhw));

  rvmss_cpu_model u_cpu (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .go_in(go), .num_in(num), .vec_valid_in(vvalid), .vec_addr_in(vaddr),
    .vec_hw_in(vhw), .fetch_req_out(freq), .fetch_num_out(fnum),
    .done_out(done), .addr_out(maddr), .hw_out(mhw));

  task automatic chk(input string n, input logic [63:0] e,
                     input logic [63:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %0h got %0h", n, e, g);
    end
  endtask : chk

  task automatic wr_reg(input logic [11:0] a, input logic [23:0] d);
    @(posedge ref_clk_in) begin wr <= 1'b1; addr <= a; wdata <= d; end
    @(posedge ref_clk_in) wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [11:0] a, output logic [23:0] d);
    @(posedge ref_clk_in) begin rd <= 1'b1; addr <= a; end
    @(posedge ref_clk_in) rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // fetch through the cpu model, then compare address and source flag
  task automatic fetch(input int n);
    logic [BASE_W-1:0] ea;
    ea = base + BASE_W'(4 * n);
    @(posedge ref_clk_in) begin go <= 1'b1; num <= VEC_NUM_W'(n); end
    @(posedge ref_clk_in) go <= 1'b0;
    for (int k = 0; k < 10 && done !== 1'b1; k++) @(posedge ref_clk_in);
    #1 chk("vec_addr", 64'(ea), 64'(maddr));
    chk("vec_hw", 64'((n >= 4 && n <= 31) || (n >= 41 && n <= 51) ||
        n == 59 || n == 60), 64'(mhw));
  endtask : fetch

  task automatic do_reset();
    @(posedge ref_clk_in) resetn_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
  endtask : do_reset

  task automatic finish_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  initial begin
    #200000;
    n_errors++;
    finish_test();
  end

  initial begin
    logic [23:0] d;
    int e;
    int v;
    do_reset();
    chk("pending_reset", 64'h0, pending_out);
    // reset values, then write and read back every register
    for (int i = 0; i < 9; i++) begin
      rd_reg(OFS[i], d);
      chk("reg_reset", 64'h0, 64'(d));
      wr_reg(OFS[i], (i < 5) ? 24'(8'hA5 ^ i) : 24'hC35A00 + 24'(i));
      rd_reg(OFS[i], d);
      chk("reg_rw", (i < 5) ? 64'(8'hA5 ^ i) : 64'hC35A00 + i, 64'(d));
    end
    // unmapped place reads zero, and read data last only one cycle
    wr_reg(12'h208, 24'h0000FF);
    rd_reg(12'h208, d);
    chk("unmapped", 64'h0, 64'(d));
    @(posedge ref_clk_in) #1 chk("rdata_idle", 64'h0, 64'(rdata));
    base = 20'h5A000;
    // every vector: address from base plus four times number
    for (int n = 0; n < 64; n++) fetch(n);
    chk("no_sw_pending", 64'h0, pending_out);
    // routing table: one event, one vector or none (FF), cleared by fetch when pended
    foreach (ROWS[i]) begin
      e = int'(ROWS[i][23:16]);
      v = int'(ROWS[i][7:0]);
      wr_reg(OFS_SEL_SECOND, 24'(ROWS[i][15:8]));
      @(posedge ref_clk_in) ev[e] <= 1'b1;
      @(posedge ref_clk_in) ev[e] <= 1'b0;
      #1 chk("route", (v == 255) ? 64'h0 : 64'h1 << v, pending_out);
      if (v != 255) begin
        fetch(v);
        chk("ack_clear", 64'h0, pending_out);
      end
    end
    // external pins, active on the falling edge
    for (int p = 0; p < 3; p++) begin
      @(posedge ref_clk_in) pin[p] <= 1'b0;
      for (int k = 0; k < 8 && pending_out[29+p] !== 1'b1; k++)
        @(posedge ref_clk_in);
      #1 chk("pin", 64'h1 << (29 + p), pending_out);
      pin[p] <= 1'b1;
      fetch(29 + p);
      chk("pin_clear", 64'h0, pending_out);
    end
    // a new request in the fetch cycle wins over the clear
    @(posedge ref_clk_in) ev[0] <= 1'b1;
    @(posedge ref_clk_in) ev[0] <= 1'b0;
    @(posedge ref_clk_in) begin go <= 1'b1; num <= 6'h29; end
    @(posedge ref_clk_in) begin go <= 1'b0; ev[0] <= 1'b1; end
    @(posedge ref_clk_in) ev[0] <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1 chk("set_wins", 64'h1 << 41, pending_out);
    // reset in mid-run clears pending and select state
    wr_reg(OFS_SEL_SECOND, 24'h00003C);
    do_reset();
    chk("pending_rst2", 64'h0, pending_out);
    rd_reg(OFS_SEL_SECOND, d);
    chk("sel_rst2", 64'h0, 64'(d));
    finish_test();
  end
endmodule : tb_top
